// [rtl/serial_lin_port.sv]
/*
  Asynchronous serial port with LIN extensions: baud measurement with
  overflow and abort, wake on break, break transmission, break receipt.
  Assumes software on a plain strobe port, inputs synchronous to mclk,
  and a single mclk; sleep freezes the bit engines but not wake logic.
*/
// Functional notes
// - Measure counter overflow before fifth edge sets flag
// - Count continues; fifth edge sets rx flag, clears enable
// - Reading receive data clears measure-done rx flag
// - Software writes clear overflow; completion leaves it
// - Overflow clear refused while measure enable set
// - Sleep stops bit engines; wake only asynchronous mode
// - Wake enable disables reception, port watches line
// - Falling line edge is wake event, sets rx flag
// - Wake flag sets in sleep too; data read clears
// - Rising edge ending break clears wake enable
// - Nonzero character wakes at first rise, fragment follows
// - Remote break must last at least ten bits
// - Software checks receive idle before enabling wake
// - Break is start, twelve zeros, stop
// - Data write with send-break starts break, data ignored
// - Send-break clears after break stop; preload follows
// - Shift-empty reports break activity like characters
// - Software sequence: enables, dummy write, then sync
// - Transmit flag set while transmit data empty
// - Break received shows rx flag, framing error, zero
// - Wake edges flag, then next byte flags again
// - Measure enable may be set before sleep
// - Measurement spans first to fifth rising edge
// - With wake enable, measurement waits for following byte
`timescale 1ns/1ps
module serial_lin_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Software port
  input wire logic [serial_lin_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Power state and flags
  input wire logic sleep,
  output logic rx_irq,
  output logic tx_irq,
  // Link
  serial_link_if.port_end link
);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

  // ==========================================================
  // Decode and line edges
  logic wr_baud, wr_tx, wr_txd, wr_lo, wr_hi, rd_rxd; // Access strobes
  logic line_prev; // Receive line one clock ago
  logic fall, rise; // Line edges
  assign wr_baud = wr && (addr == serial_lin_pkg::OFS_BAUD_CTRL);
  assign wr_tx = wr && (addr == serial_lin_pkg::OFS_TX_CTRL);
  assign wr_txd = wr && (addr == serial_lin_pkg::OFS_TX_DATA);
  assign wr_lo = wr && (addr == serial_lin_pkg::OFS_DIV_LOW);
  assign wr_hi = wr && (addr == serial_lin_pkg::OFS_DIV_HIGH);
  assign rd_rxd = rd && (addr == serial_lin_pkg::OFS_RX_DATA);
  assign fall = line_prev && !link.receive_line;
  assign rise = !line_prev && link.receive_line;

  // Edge reference
  always_ff @(posedge mclk) begin
    if (!resetn) line_prev <= 1'b1;
    else line_prev <= link.receive_line;
  end

  // ==========================================================
  // Control bits
  logic meas_en, wake_en, meas_ovf, send_break, tx_en; // Software bits
  logic [15:0] divisor; // Bit time minus one, in clocks
  logic meas_done, meas_wrap, break_done; // Hardware events
  logic [16:0] meas_cnt; // Measure count, bit 16 stays zero; the count wraps from 16'hFFFF to 16'h0000

  // Baud control; hardware clears only when software is not writing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meas_en <= 1'b0;
      wake_en <= 1'b0;
    end else if (wr_baud) begin
      meas_en <= wdata[serial_lin_pkg::BIT_MEAS_EN];
      wake_en <= wdata[serial_lin_pkg::BIT_WAKE_EN];
    end else begin
      if (meas_done) meas_en <= 1'b0;
      if (wake_en && rise) wake_en <= 1'b0;
    end
  end

  // Overflow flag; a wrap in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (!resetn) meas_ovf <= 1'b0;
    else if (meas_wrap) meas_ovf <= 1'b1;
    else if (wr_baud && !wdata[serial_lin_pkg::BIT_MEAS_OVF] && !meas_en) meas_ovf <= 1'b0;
  end

  // Transmit control; send-break drops after the break stop bit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      send_break <= 1'b0;
      tx_en <= 1'b0;
    end else if (wr_tx) begin
      send_break <= wdata[serial_lin_pkg::BIT_SEND_BREAK];
      tx_en <= wdata[serial_lin_pkg::BIT_TX_EN];
    end else if (break_done) begin
      send_break <= 1'b0;
    end
  end

  // Divisor; loaded by software or by a finished measurement
  always_ff @(posedge mclk) begin
    if (!resetn) divisor <= serial_lin_pkg::DIVISOR_RESET;
    else if (meas_done) divisor <= meas_cnt[15:0];
    else if (wr_lo) divisor[7:0] <= wdata;
    else if (wr_hi) divisor[15:8] <= wdata;
  end

  // ==========================================================
  // Baud measurement; held off while wake enable waits for the break
  logic [2:0] meas_edges; // Rising edges seen
  logic [2:0] meas_pre; // Clock/8 prescaler
  logic meas_run; // Measurement may proceed
  assign meas_run = meas_en && !wake_en && !sleep;
  assign meas_done = meas_run && rise && (meas_edges == 3'(serial_lin_pkg::MEAS_EDGES - 1));
  assign meas_wrap = meas_run && (meas_edges != 3'h0) && !meas_done &&
                     (meas_pre == 3'(serial_lin_pkg::MEAS_PRESCALE - 1)) && (meas_cnt[15:0] == 16'hFFFF);

  // Counter starts at 1 on the first rise and keeps going past a wrap
  always_ff @(posedge mclk) begin
    if (!resetn || !meas_run) begin
      meas_edges <= 3'h0;
      meas_pre <= 3'h0;
      meas_cnt <= 17'h00000;
    end else if (meas_done) begin
      meas_edges <= 3'h0;
    end else if (rise && (meas_edges == 3'h0)) begin
      meas_edges <= 3'h1;
      meas_pre <= 3'h0;
      meas_cnt <= 17'h00001;
    end else if (meas_edges != 3'h0) begin
      if (rise) meas_edges <= meas_edges + 3'h1;
      meas_pre <= meas_pre + 3'h1;
      if (meas_pre == 3'(serial_lin_pkg::MEAS_PRESCALE - 1)) begin
        meas_cnt <= {1'b0, meas_cnt[15:0] + 16'h0001};
      end
    end
  end

  // ==========================================================
  // Receiver; idle while waking or measuring
  rx_state_t rx_state;
  logic [15:0] rx_timer; // Clocks to next sample point
  logic [2:0] rx_bit; // Data bit index
  logic [7:0] rx_shift; // Incoming bits
  logic [7:0] rx_data; // receive_data_reg
  logic framing; // framing_error_flag
  logic rx_flag; // receive_irq_flag
  logic rx_done; // Character complete

  assign rx_done = (rx_state == RX_STOP) && (rx_timer == 16'h0000) && !sleep;

  // Bit engine, sampling at mid bit; frozen in sleep
  always_ff @(posedge mclk) begin
    if (!resetn || wake_en || meas_en) begin
      rx_state <= RX_IDLE;
      rx_timer <= 16'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
    end else if (!sleep) begin
      if (rx_state != RX_IDLE) begin
        rx_timer <= (rx_timer == 16'h0000) ? divisor : rx_timer - 16'h0001;
      end
      case (rx_state)
        RX_IDLE: begin
          if (fall) begin
            rx_state <= RX_START;
            rx_timer <= {1'b0, divisor[15:1]};
          end
        end
        RX_START: begin
          if (rx_timer == 16'h0000) rx_state <= link.receive_line ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rx_timer == 16'h0000) begin
            rx_shift <= {link.receive_line, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'(serial_lin_pkg::DATA_BITS - 1)) rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_timer == 16'h0000) rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Received character and framing result; a low stop bit marks a break
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rx_data <= 8'h00;
      framing <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      framing <= !link.receive_line;
    end
  end

  // Receive flag; any set wins over the clearing read
  always_ff @(posedge mclk) begin
    if (!resetn) rx_flag <= 1'b0;
    else if (rx_done || meas_done || (wake_en && fall)) rx_flag <= 1'b1;
    else if (rd_rxd) rx_flag <= 1'b0;
  end

  // ==========================================================
  // Transmitter with one holding byte
  tx_state_t tx_state;
  logic hold_valid, hold_break; // Holding slot full, holds a break
  logic [7:0] hold_data; // transmit_data_reg
  logic [7:0] tx_shift; // Outgoing bits
  logic tx_is_break; // Shifter carries a break
  logic [3:0] tx_bit; // Bits sent
  logic [15:0] tx_timer; // Clocks left in bit
  logic tx_line; // Line drive
  logic tx_load; // Holding byte moves to the shifter
  logic tx_tick; // Bit boundary
  assign tx_load = (tx_state == TX_IDLE) && hold_valid && tx_en && !sleep;
  assign tx_tick = (tx_timer == 16'h0000) && !sleep;
  assign break_done = (tx_state == TX_STOP) && tx_tick && tx_is_break;
  assign link.transmit_line = tx_line;

  // Holding slot; a write into a full slot is dropped
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_valid <= 1'b0;
      hold_break <= 1'b0;
      hold_data <= 8'h00;
    end else if (tx_load) begin
      hold_valid <= 1'b0;
    end else if (wr_txd && tx_en && !hold_valid) begin
      hold_valid <= 1'b1;
      hold_data <= wdata;
      // Only the first write after send-break is a break; the next is data
      hold_break <= send_break && !(tx_state != TX_IDLE && tx_is_break);
    end
  end

  // Shift engine; a break sends zeros in place of the written value
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= 8'h00;
      tx_is_break <= 1'b0;
      tx_bit <= 4'h0;
      tx_timer <= 16'h0000;
      tx_line <= 1'b1;
    end else if (tx_load) begin
      tx_state <= TX_START;
      tx_shift <= hold_break ? 8'h00 : hold_data;
      tx_is_break <= hold_break;
      tx_bit <= 4'h0;
      tx_timer <= divisor;
      tx_line <= 1'b0;
    end else if (tx_state != TX_IDLE && !sleep) begin
      tx_timer <= tx_tick ? divisor : tx_timer - 16'h0001;
      if (tx_tick) begin
        case (tx_state)
          TX_START, TX_DATA: begin
            if (tx_state == TX_DATA && tx_bit == (tx_is_break ? 4'(serial_lin_pkg::BREAK_ZERO_BITS)
                                                              : 4'(serial_lin_pkg::DATA_BITS))) begin
              tx_state <= TX_STOP;
              tx_line <= 1'b1;
            end else begin
              tx_state <= TX_DATA;
              tx_line <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit <= tx_bit + 4'h1;
            end
          end
          TX_STOP: tx_state <= TX_IDLE;
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Readback, one cycle after the read strobe
  assign rx_irq = rx_flag;
  assign tx_irq = !hold_valid;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        serial_lin_pkg::OFS_BAUD_CTRL: rdata <= {meas_ovf, rx_state == RX_IDLE, 4'h0, wake_en, meas_en};
        serial_lin_pkg::OFS_TX_CTRL: rdata <= {2'h0, tx_en, 1'b0, send_break, 1'b0, tx_state == TX_IDLE, 1'b0};
        serial_lin_pkg::OFS_RX_STATUS: rdata <= {5'h00, framing, 2'h0};
        serial_lin_pkg::OFS_RX_DATA: rdata <= rx_data;
        serial_lin_pkg::OFS_DIV_LOW: rdata <= divisor[7:0];
        serial_lin_pkg::OFS_DIV_HIGH: rdata <= divisor[15:8];
        serial_lin_pkg::OFS_IRQ: rdata <= {6'h00, !hold_valid, rx_flag};
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule

// [pkg/serial_lin_pkg.sv]
/*
  Shared constants for the LIN-capable serial port: register offsets,
  bit positions, reset values and character counts.
  Assumes both ends and the bench refer to names here by package scope.
*/
package serial_lin_pkg;
  // ==========================================================
  // Register map
  localparam int ADDR_W = 3; // Register address width
  localparam logic [2:0] OFS_BAUD_CTRL = 3'h0; // baud_control_reg
  localparam logic [2:0] OFS_TX_CTRL = 3'h1; // transmit_status_control_reg
  localparam logic [2:0] OFS_RX_STATUS = 3'h2; // receive_status_control_reg
  localparam logic [2:0] OFS_TX_DATA = 3'h3; // transmit_data_reg, write only
  localparam logic [2:0] OFS_RX_DATA = 3'h4; // receive_data_reg, read only
  localparam logic [2:0] OFS_DIV_LOW = 3'h5; // baud_divisor_low
  localparam logic [2:0] OFS_DIV_HIGH = 3'h6; // baud_divisor_high
  localparam logic [2:0] OFS_IRQ = 3'h7; // Interrupt flags, read only
  // ==========================================================
  // Field positions
  localparam int BIT_MEAS_EN = 0; // baud_measure_enable
  localparam int BIT_WAKE_EN = 1; // wake_on_break_enable
  localparam int BIT_RX_IDLE = 6; // receive_idle_status
  localparam int BIT_MEAS_OVF = 7; // baud_measure_overflow_flag
  localparam int BIT_SHIFT_EMPTY = 1; // shift_empty_status
  localparam int BIT_SEND_BREAK = 3; // send_break_bit
  localparam int BIT_TX_EN = 5; // transmit_enable
  localparam int BIT_FRAMING = 2; // framing_error_flag
  localparam int BIT_RX_IRQ = 0; // receive_irq_flag
  localparam int BIT_TX_IRQ = 1; // transmit_irq_flag
  // ==========================================================
  // Reset values and counts
  localparam logic [15:0] DIVISOR_RESET = 16'h0067; // Bit time is divisor+1 clocks
  localparam int DATA_BITS = 8; // Data bits per character
  localparam int BREAK_ZERO_BITS = 12; // Zero bits after a break start bit
  localparam int MEAS_EDGES = 5; // Rising edges in a sync character
  localparam int MEAS_PRESCALE = 8; // Measure counter runs at clock/8
  localparam int LIN_BREAK_BITS = 13; // Recommended low time of a wake break
  localparam logic [7:0] SYNC_CHAR = 8'h55; // LIN sync value
endpackage

// [pkg/serial_link_if.sv]
/*
  The two serial lines between the port and the remote node.
  Assumes both ends run on the same mclk, supplied separately.
*/
`timescale 1ns/1ps
interface serial_link_if;
  // ==========================================================
  // Lines, both idle high
  logic receive_line; // Remote node to port
  logic transmit_line; // Port to remote node

  modport port_end (input receive_line, output transmit_line);
  modport remote_end (output receive_line, input transmit_line);
endinterface

// [rtl/serial_remote_node.sv]
/*
  Remote serial node: sends bytes or a long all-zero break on demand and
  receives bytes from the port. Assumes the user keeps bit_period fixed
  while busy and that mclk is shared with the port.
*/
`timescale 1ns/1ps
module serial_remote_node #(
  parameter int BREAK_BITS = serial_lin_pkg::LIN_BREAK_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link
  serial_link_if.remote_end link,
  // User side
  input wire logic [15:0] bit_period,
  input wire logic send_byte,
  input wire logic send_break,
  input wire logic [7:0] byte_in,
  output logic busy,
  output logic [7:0] byte_out,
  output logic byte_valid,
  output logic byte_framing
);
  // ==========================================================
  // Transmitter toward the port
  logic [15:0] tx_timer; // Clocks left in current bit
  logic [9:0] tx_frame; // Start, data, stop, shifted out LSB first
  logic [4:0] tx_left; // Bits left, break included
  logic tx_line; // Line state

  assign link.receive_line = tx_line;
  assign busy = (tx_left != 5'h00);

  // Bit sequencer; a break holds the line low for BREAK_BITS then idles high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_timer <= 16'h0000;
      tx_frame <= 10'h3FF;
      tx_left <= 5'h00;
      tx_line <= 1'b1;
    end else if (!busy) begin
      if (send_break) begin
        tx_frame <= 10'h000;
        tx_left <= 5'(BREAK_BITS + 1);
        tx_line <= 1'b0;
        tx_timer <= bit_period;
      end else if (send_byte) begin
        tx_frame <= {1'b1, byte_in, 1'b0};
        tx_left <= 5'h0A;
        tx_line <= 1'b0;
        tx_timer <= bit_period;
      end
    end else if (tx_timer != 16'h0000) begin
      tx_timer <= tx_timer - 16'h0001;
    end else begin
      // Bit over; after the last one the line returns high
      tx_timer <= bit_period;
      tx_left <= tx_left - 5'h01;
      // Zeros shift in, so a break frame stays low until its last bit
      tx_frame <= {1'b0, tx_frame[9:1]};
      tx_line <= (tx_left <= 5'h02) ? 1'b1 : tx_frame[1];
    end
  end

  // ==========================================================
  // Receiver from the port
  logic line_prev; // Last line sample
  logic [15:0] rx_timer; // Clocks to next sample point
  logic [3:0] rx_count; // Samples taken in this frame
  logic rx_busy; // Frame in progress
  logic [7:0] rx_shift; // Incoming data

  // Mid-bit sampler; a falling edge while idle starts a frame
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      line_prev <= 1'b1;
      rx_timer <= 16'h0000;
      rx_count <= 4'h0;
      rx_busy <= 1'b0;
      rx_shift <= 8'h00;
      byte_out <= 8'h00;
      byte_valid <= 1'b0;
      byte_framing <= 1'b0;
    end else begin
      line_prev <= link.transmit_line;
      byte_valid <= 1'b0;
      if (!rx_busy) begin
        if (line_prev && !link.transmit_line) begin
          rx_busy <= 1'b1;
          rx_count <= 4'h0;
          rx_timer <= {1'b0, bit_period[15:1]};
        end
      end else if (rx_timer != 16'h0000) begin
        rx_timer <= rx_timer - 16'h0001;
      end else begin
        rx_timer <= bit_period;
        rx_count <= rx_count + 4'h1;
        if (rx_count == 4'h9) begin // Stop bit sample
          rx_busy <= 1'b0;
          byte_out <= rx_shift;
          byte_valid <= 1'b1;
          byte_framing <= !link.transmit_line;
        end else if (rx_count != 4'h0) begin
          rx_shift <= {link.transmit_line, rx_shift[7:1]};
        end
      end
    end
  end
endmodule

// [sim/serial_lin_chk.sv]
/*
  Checker on the link and the software port of the serial port.
  Assumes the bench instantiates it beside the link interface and the
  divisor stays at its reset value whenever the port transmits.
*/
`timescale 1ns/1ps
module serial_lin_chk #(
  parameter int BIT_CLKS = 104
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Software port
  input wire logic [serial_lin_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sleep,
  input wire logic rx_irq,
  input wire logic tx_irq,
  // Link lines
  input wire logic receive_line,
  input wire logic transmit_line
);
  // ==========================================================
  // Helper logic
  logic [15:0] tx_low; // Low run on the transmit line
  logic [15:0] rx_low; // Low run on the receive line
  logic [15:0] tx_high; // High run, saturating
  logic tx_en_s; // Transmit enable as software last wrote it
  logic tx_go; // Data write into an idle transmitter

  // Low runs restart whenever the line is high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_low <= 16'h0000;
      rx_low <= 16'h0000;
    end else begin
      tx_low <= transmit_line ? 16'h0000 : tx_low + 16'h0001;
      rx_low <= receive_line ? 16'h0000 : rx_low + 16'h0001;
    end
  end

  // Starts full, so a character right after reset is not flagged
  always_ff @(posedge mclk) begin
    if (!resetn || (transmit_line && tx_high == 16'hFFFF)) begin
      tx_high <= 16'hFFFF;
    end else begin
      tx_high <= transmit_line ? tx_high + 16'h0001 : 16'h0000;
    end
  end

  // Only software changes transmit enable
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_en_s <= 1'b0;
    end else if (wr && addr == serial_lin_pkg::OFS_TX_CTRL) begin
      tx_en_s <= wdata[serial_lin_pkg::BIT_TX_EN];
    end
  end

  // Over ten bit times high means the shifter is idle; the line must still be high,
  // since the run counter lags a load made one cycle earlier
  assign tx_go = wr && addr == serial_lin_pkg::OFS_TX_DATA && tx_en_s && tx_irq && transmit_line &&
                 tx_high > 16'(10 * BIT_CLKS);

  // ==========================================================
  // Assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  reset_idle_a: assert property (disable iff (1'b0) !resetn |=> transmit_line && receive_line && tx_irq && !rx_irq && rdata == 8'h00)
    else $error("outputs not idle after reset");
  tx_frame_a: assert property ($rose(transmit_line) |-> tx_low % BIT_CLKS == 0 && (tx_low <= 9 * BIT_CLKS || tx_low == 13 * BIT_CLKS))
    else $error("transmit low run of wrong length");
  rx_frame_a: assert property ($rose(receive_line) |-> rx_low % BIT_CLKS == 0 && (rx_low <= 9 * BIT_CLKS || rx_low == 13 * BIT_CLKS))
    else $error("remote low run of wrong length");
  stop_len_a: assert property ($fell(transmit_line) |-> tx_high >= BIT_CLKS)
    else $error("stop bit too short");
  tx_start_a: assert property (tx_go |-> ##[1:3] !transmit_line)
    else $error("write to idle transmitter did not start");
  tx_irq_a: assert property (tx_go |=> !tx_irq ##[1:3] tx_irq)
    else $error("transmit flag did not follow the load");
  rd_clear_a: assert property (rd && addr == serial_lin_pkg::OFS_RX_DATA && receive_line && $past(receive_line) |=> !rx_irq)
    else $error("receive data read left receive flag set");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  sleep_hold_a: assert property (sleep && $past(sleep) && transmit_line |=> transmit_line)
    else $error("transmitter moved during sleep");
endmodule

// [sim/serial_lin_port_tb.sv]
/*
  Self-checking bench: port and remote node joined over the link.
  Assumes the remote keeps the divisor's bit time of 104 clocks.
*/
`timescale 1ns/1ps
module serial_lin_port_tb;
  // ==========================================================
  // Signals
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic send_byte = 1'b0;
  logic send_break = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] byte_in = 8'h00;
  logic [15:0] bit_period = 16'h0067; // Matches the divisor reset value
  logic [7:0] rdata, byte_out, d;
  logic rx_irq, tx_irq, busy, byte_valid, byte_framing;
  int error_cnt = 0;
  int cmp_count = 0;

  serial_link_if i_serial_link_if();
  serial_lin_port i_serial_lin_port (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sleep(sleep), .rx_irq(rx_irq), .tx_irq(tx_irq), .link(i_serial_link_if.port_end));
  serial_remote_node i_serial_remote_node (.mclk(mclk), .resetn(resetn), .link(i_serial_link_if.remote_end),
    .bit_period(bit_period), .send_byte(send_byte), .send_break(send_break), .byte_in(byte_in), .busy(busy),
    .byte_out(byte_out), .byte_valid(byte_valid), .byte_framing(byte_framing));
  serial_lin_chk i_serial_lin_chk (.mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sleep(sleep), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .receive_line(i_serial_link_if.receive_line), .transmit_line(i_serial_link_if.transmit_line));

  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  task automatic rreg(input logic [2:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  // Remote request; break wins over byte
  task automatic rem_send(input logic brk, input logic [7:0] b);
    @(posedge mclk);
    byte_in <= b;
    send_break <= brk;
    send_byte <= ~brk;
    @(posedge mclk);
    send_break <= 1'b0;
    send_byte <= 1'b0;
  endtask

  // Bounded wait: 0 receive flag, 1 remote byte, 2 remote idle
  task automatic await(input int sel, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge mclk);
      if ((sel == 0 && rx_irq === 1'b1) || (sel == 1 && byte_valid === 1'b1) || (sel == 2 && busy === 1'b0)) break;
    end
    if (n == lim) begin
      $display("mismatch wait %0d expected 1 seen 0", sel);
      error_cnt++;
      stop_test();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rreg(serial_lin_pkg::OFS_TX_CTRL);
    check("tx ctrl", 8'h02, d & 8'h2A);
    rreg(serial_lin_pkg::OFS_DIV_LOW);
    check("divisor low", 8'h67, d);
    wreg(serial_lin_pkg::OFS_IRQ, 8'h00);
    rreg(serial_lin_pkg::OFS_IRQ);
    check("flags", 8'h02, d & 8'h03);
    wreg(serial_lin_pkg::OFS_BAUD_CTRL, 8'h01);
    wreg(serial_lin_pkg::OFS_BAUD_CTRL, 8'h00);
    rreg(serial_lin_pkg::OFS_BAUD_CTRL);
    check("abort", 8'h40, d & 8'hC3);
    $display("test reset done");
  endtask

  // Header: break from a dummy write, then the queued sync
  task automatic t_break_tx();
    wreg(serial_lin_pkg::OFS_TX_CTRL, 8'h28);
    wreg(serial_lin_pkg::OFS_TX_DATA, 8'hA5);
    wreg(serial_lin_pkg::OFS_TX_DATA, serial_lin_pkg::SYNC_CHAR);
    rreg(serial_lin_pkg::OFS_TX_CTRL);
    check("tx busy", 8'h28, d & 8'h2A);
    check("slot full", 8'h00, 8'(tx_irq));
    await(1, 2000);
    check("break data", 8'h00, byte_out);
    check("break stop", 8'h01, 8'(byte_framing));
    await(1, 2000);
    check("sync data", serial_lin_pkg::SYNC_CHAR, byte_out);
    await(2, 200);
    repeat (60) @(negedge mclk);
    rreg(serial_lin_pkg::OFS_TX_CTRL);
    check("tx idle", 8'h22, d & 8'h2A);
    check("slot empty", 8'h01, 8'(tx_irq));
    $display("test break transmit done");
  endtask

  // Ordinary byte, then a break seen as zero data with bad stop
  task automatic t_receive(input logic brk, input logic [7:0] v);
    rem_send(brk, v);
    await(0, 1500);
    rreg(serial_lin_pkg::OFS_RX_STATUS);
    check("framing", 8'(brk) << 2, d & 8'h04);
    rreg(serial_lin_pkg::OFS_RX_DATA);
    check("rx data", brk ? 8'h00 : v, d);
    check("rx flag read", 8'h00, 8'(rx_irq));
    await(2, 1500);
    repeat (200) @(negedge mclk);
    $display("test receive done");
  endtask

  // Wake from sleep on a break, then measure the sync
  task automatic t_wake();
    rreg(serial_lin_pkg::OFS_BAUD_CTRL);
    check("rx idle", 8'h40, d & 8'h40);
    wreg(serial_lin_pkg::OFS_BAUD_CTRL, 8'h03);
    sleep <= 1'b1;
    rem_send(1'b1, 8'h00);
    await(0, 20);
    await(2, 1500);
    sleep <= 1'b0;
    rreg(serial_lin_pkg::OFS_BAUD_CTRL);
    check("wake cleared", 8'h01, d & 8'h03);
    rreg(serial_lin_pkg::OFS_RX_DATA);
    check("wake flag read", 8'h00, 8'(rx_irq));
    rem_send(1'b0, serial_lin_pkg::SYNC_CHAR);
    await(0, 1500);
    rreg(serial_lin_pkg::OFS_BAUD_CTRL);
    check("measure done", 8'h00, d & 8'h81);
    rreg(serial_lin_pkg::OFS_DIV_LOW);
    check("measured", 8'h01, 8'(d == 8'h68 || d == 8'h69));
    rreg(serial_lin_pkg::OFS_RX_DATA);
    wreg(serial_lin_pkg::OFS_DIV_LOW, 8'h67);
    $display("test wake done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_break_tx();
    t_receive(1'b0, 8'hA3);
    t_receive(1'b1, 8'h00);
    t_wake();
    stop_test();
  end
endmodule
